// *** pkg/bsac_pkg.sv ***
package bsac_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] BSAC_IDX_INSERT_CTL  = 8'h08;
  localparam logic [7:0] BSAC_IDX_STATUS      = 8'h0C;
  localparam logic [7:0] BSAC_IDX_LATCHED     = 8'h0E;
  localparam logic [7:0] BSAC_IDX_IRQ_EN      = 8'h10;
  localparam logic [7:0] BSAC_IDX_UPDATE_CTL  = 8'h12;
  localparam logic [7:0] BSAC_IDX_ERR_CNT0    = 8'h14;
  localparam logic [7:0] BSAC_IDX_ERR_CNT1    = 8'h15;
  localparam logic [7:0] BSAC_IDX_ERR_CNT2    = 8'h16;
  localparam logic [7:0] BSAC_IDX_BIT_CNT0    = 8'h18;
  localparam logic [7:0] BSAC_IDX_BIT_CNT1    = 8'h19;
  localparam logic [7:0] BSAC_IDX_BIT_CNT2    = 8'h1A;
  localparam logic [7:0] BSAC_IDX_BIT_CNT3    = 8'h1B;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BSAC_INS_SELECT_BIT   = 0;
  localparam int BSAC_INS_SINGLE_BIT   = 1;
  localparam int BSAC_FLAG_UPDATE      = 3;
  localparam int BSAC_FLAG_BIT_ERROR   = 2;
  localparam int BSAC_FLAG_NONZERO     = 1;
  localparam int BSAC_FLAG_UNLOCK      = 0;
  localparam int BSAC_UPD_LOCAL_BIT    = 0;
  localparam int BSAC_UPD_SELECT_BIT   = 1;
  localparam int BSAC_UPD_NO_RESYNC    = 2;
  localparam int BSAC_UPD_MAN_RESYNC   = 3;

  // ****************************************************************
  // Widths, reset values and checker timing
  // ****************************************************************
  localparam int BSAC_ERR_W           = 24;
  localparam int BSAC_BIT_W           = 32;
  localparam logic [7:0] BSAC_REG_RST = 8'h00;
  localparam int BSAC_WINDOW_BITS     = 64;
  localparam int BSAC_MISS_LIMIT      = 6;
  localparam int BSAC_LOCK_RUN        = 32;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef enum logic [1:0]
  {
    BSAC_HUNT   = 2'b01,
    BSAC_LOCKED = 2'b10
  } bsac_chk_state_t;

  typedef struct packed
  {
    logic rx_bit_valid;
    logic rx_bit_mismatch;
    logic no_auto_resync;
    logic manual_resync;
  } bsac_chk_in_t;

  typedef struct packed
  {
    logic checker_unlocked;
    logic bit_error;
  } bsac_chk_out_t;

endpackage

// *** logic/bsac_sync_checker.sv ***
`timescale 1ns/100ps

// ****************************************************************
// Receive sync checker: hunts, locks, drops lock on dense mismatches
// ****************************************************************
module bsac_sync_checker
  import bsac_pkg::*;
#(
  parameter int WINDOW_BITS = BSAC_WINDOW_BITS,
  parameter int MISS_LIMIT  = BSAC_MISS_LIMIT,
  parameter int LOCK_RUN    = BSAC_LOCK_RUN
)
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire bsac_chk_in_t  chk_in,
  output bsac_chk_out_t      chk_out
);

  typedef struct packed
  {
    bsac_chk_state_t state;
    logic [6:0]      bit_idx;
    logic [3:0]      miss_cnt;
    logic [6:0]      run_cnt;
    bsac_chk_out_t   out;
  } bsac_chk_st_t;

  localparam bsac_chk_st_t CHK_RST = '{state: BSAC_HUNT, bit_idx: 7'h00, miss_cnt: 4'h0,
                                       run_cnt: 7'h00, out: 2'h2};

  bsac_chk_st_t st_ff;
  bsac_chk_st_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.out.bit_error = 1'b0;
    case (st_ff.state)
      BSAC_HUNT:
      begin
        if (chk_in.rx_bit_valid)
        begin
          if (chk_in.rx_bit_mismatch)
            nxt_st.run_cnt = 7'h00;
          else if (st_ff.run_cnt == 7'(LOCK_RUN - 1))
          begin
            nxt_st.state    = BSAC_LOCKED;
            nxt_st.bit_idx  = 7'h00;
            nxt_st.miss_cnt = 4'h0;
          end
          else
            nxt_st.run_cnt = st_ff.run_cnt + 7'h01;
        end
      end
      BSAC_LOCKED:
      begin
        if (chk_in.rx_bit_valid)
        begin
          nxt_st.out.bit_error = chk_in.rx_bit_mismatch;
          if (st_ff.bit_idx == 7'(WINDOW_BITS - 1))
          begin
            nxt_st.bit_idx  = 7'h00;
            nxt_st.miss_cnt = 4'h0;
          end
          else
          begin
            nxt_st.bit_idx  = st_ff.bit_idx + 7'h01;
            nxt_st.miss_cnt = st_ff.miss_cnt + {3'h0, chk_in.rx_bit_mismatch};
          end
          // Limit counts the current bit too, so the sixth miss drops lock at once
          if (!chk_in.no_auto_resync && chk_in.rx_bit_mismatch &&
              (st_ff.miss_cnt + 4'h1) >= 4'(MISS_LIMIT))
          begin
            nxt_st.state   = BSAC_HUNT;
            nxt_st.run_cnt = 7'h00;
          end
        end
      end
      default:
      begin
        nxt_st.state = BSAC_HUNT;
      end
    endcase
    if (chk_in.manual_resync)
    begin
      nxt_st.state   = BSAC_HUNT;
      nxt_st.run_cnt = 7'h00;
    end
    nxt_st.out.checker_unlocked = (nxt_st.state != BSAC_LOCKED);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= CHK_RST;
    else
      st_ff <= nxt_st;
  end

  assign chk_out = st_ff.out;

endmodule // bsac_sync_checker

// *** logic/bsac_top.sv ***
`timescale 1ns/100ps

// Overview of operation
// - Insert trigger comes from register single-insert bit when select 0, else external input.
// - Changing trigger select while a trigger is high may insert one error.
// - Update status rises once the counter update has completed.
// - Update status drops at once when the selected update request falls.
// - Nonzero-error status is 0 at zero count, 1 at one or more.
// - Unlocked status is 0 while the checker is locked, else 1.
// - Update latched flag sets on update status rising, clears on latched read.
// - Bit-error latched flag sets on each detected error, clears on latched read.
// - Nonzero latched flag sets on nonzero status rising, clears on latched read.
// - Unlock latched flag sets on any unlocked change, clears on latched read.
// - Each enable bit passes its latched flag to the interrupt when 1.
// - Errors count in a 24-bit counter that saturates at all ones.
// - Error counter holds while the checker is unlocked.
// - Received bits count in a 32-bit counter that saturates at all ones.
// - Bit counter holds while the checker is unlocked.
// - Checker drops lock on six mismatches in a 64-bit window unless disabled.
module bsac_top
  import bsac_pkg::*;
#(
  parameter int ADDR_W   = 12,
  parameter int ERR_W    = BSAC_ERR_W,
  parameter int BIT_W    = BSAC_BIT_W,
  parameter int LOCK_RUN = BSAC_LOCK_RUN
)
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rx_bit_valid,
  input  wire logic              rx_bit_mismatch,
  input  wire logic              external_insert_input,
  input  wire logic              external_update_request,
  output logic                   insert_trigger,
  output logic                   checker_unlocked,
  output logic                   irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed
  {
    logic [ERR_W-1:0] err_cnt;
    logic [BIT_W-1:0] bit_cnt;
    logic [ERR_W-1:0] err_snap;
    logic [BIT_W-1:0] bit_snap;
    logic             upd_done;
    logic             upd_req_prev;
    logic             upd_stat_prev;
    logic             nz_prev;
    logic             unl_prev;
    logic             resync_prev;
    logic [3:0]       latched;
    logic [3:0]       irq_en;
    logic [1:0]       ins_ctl;
    logic [3:0]       upd_ctl;
    logic [31:0]      rdata;
    logic             slverr;
    logic             irq;
  } bsac_top_st_t;

  // Unlocked status resets high, so its change detector does too: no false change after reset
  localparam bsac_top_st_t TOP_RST = '{
    err_cnt:       '0,
    bit_cnt:       '0,
    err_snap:      '0,
    bit_snap:      '0,
    upd_done:      1'b0,
    upd_req_prev:  1'b0,
    upd_stat_prev: 1'b0,
    nz_prev:       1'b0,
    unl_prev:      1'b1,
    resync_prev:   1'b0,
    latched:       BSAC_REG_RST[3:0],
    irq_en:        BSAC_REG_RST[3:0],
    ins_ctl:       BSAC_REG_RST[1:0],
    upd_ctl:       BSAC_REG_RST[3:0],
    rdata:         32'h00000000,
    slverr:        1'b0,
    irq:           1'b0
  };

  bsac_top_st_t  st_ff;
  bsac_top_st_t  nxt_st;
  bsac_chk_in_t  chk_in;
  bsac_chk_out_t chk_out;

  logic       upd_req;
  logic       upd_status;
  logic       nonzero_status;
  logic [3:0] status_bits;
  logic [3:0] flag_set;
  logic [7:0] idx;
  logic       aligned;
  logic       setup_rd;
  logic       setup_any;
  logic       acc_wr;
  logic       acc_rd;
  logic       err_inc;
  logic       bit_inc;
  logic       upd_rise;
  logic       rd_latched;
  logic [3:0] nxt_latched;

  // ****************************************************************
  // Decode helpers
  // ****************************************************************
  function automatic logic bsac_mapped(input logic [7:0] i);
    case (i)
      BSAC_IDX_INSERT_CTL, BSAC_IDX_STATUS, BSAC_IDX_LATCHED, BSAC_IDX_IRQ_EN,
      BSAC_IDX_UPDATE_CTL, BSAC_IDX_ERR_CNT0, BSAC_IDX_ERR_CNT1, BSAC_IDX_ERR_CNT2,
      BSAC_IDX_BIT_CNT0, BSAC_IDX_BIT_CNT1, BSAC_IDX_BIT_CNT2, BSAC_IDX_BIT_CNT3:
        bsac_mapped = 1'b1;
      default:
        bsac_mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] bsac_byte(input logic [7:0] b);
    bsac_byte = {24'h000000, b};
  endfunction

  // ****************************************************************
  // Sync checker
  // ****************************************************************
  assign chk_in.rx_bit_valid    = rx_bit_valid;
  assign chk_in.rx_bit_mismatch = rx_bit_mismatch;
  assign chk_in.no_auto_resync  = st_ff.upd_ctl[BSAC_UPD_NO_RESYNC];
  assign chk_in.manual_resync   = st_ff.upd_ctl[BSAC_UPD_MAN_RESYNC] & ~st_ff.resync_prev;

  bsac_sync_checker #(
    .WINDOW_BITS (BSAC_WINDOW_BITS),
    .MISS_LIMIT  (BSAC_MISS_LIMIT),
    .LOCK_RUN    (LOCK_RUN)
  ) u_checker (
    .pclk    (pclk),
    .presetn (presetn),
    .chk_in  (chk_in),
    .chk_out (chk_out)
  );

  // ****************************************************************
  // Status and trigger selection
  // ****************************************************************
  // Plain mux, no retiming: a select change under a high trigger makes an edge
  assign insert_trigger = st_ff.ins_ctl[BSAC_INS_SELECT_BIT] ?
                          external_insert_input :
                          st_ff.ins_ctl[BSAC_INS_SINGLE_BIT];

  assign upd_req = st_ff.upd_ctl[BSAC_UPD_SELECT_BIT] ?
                   external_update_request : st_ff.upd_ctl[BSAC_UPD_LOCAL_BIT];
  // Gated by the live request so the bit falls in the same cycle the request does
  assign upd_status     = st_ff.upd_done & upd_req;
  assign nonzero_status = (st_ff.err_cnt != '0);

  always_comb
  begin
    status_bits                     = 4'h0;
    status_bits[BSAC_FLAG_UPDATE]   = upd_status;
    status_bits[BSAC_FLAG_NONZERO]  = nonzero_status;
    status_bits[BSAC_FLAG_UNLOCK]   = chk_out.checker_unlocked;
  end

  always_comb
  begin
    flag_set                        = 4'h0;
    flag_set[BSAC_FLAG_UPDATE]      = upd_status & ~st_ff.upd_stat_prev;
    flag_set[BSAC_FLAG_BIT_ERROR]   = chk_out.bit_error;
    flag_set[BSAC_FLAG_NONZERO]     = nonzero_status & ~st_ff.nz_prev;
    flag_set[BSAC_FLAG_UNLOCK]      = chk_out.checker_unlocked ^ st_ff.unl_prev;
  end

  // ****************************************************************
  // APB phases
  // ****************************************************************
  assign idx       = paddr[9:2];
  assign aligned   = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);
  assign setup_any = psel & ~penable;
  assign setup_rd  = setup_any & ~pwrite;
  assign acc_wr    = psel & penable & pwrite & aligned & ~st_ff.slverr;
  assign acc_rd    = psel & penable & ~pwrite & aligned & ~st_ff.slverr;

  // ****************************************************************
  // Counter and flag helpers
  // ****************************************************************
  // Counting stops while out of lock; the miss that drops lock counts as a bit but not as an error
  assign err_inc    = chk_out.bit_error & ~chk_out.checker_unlocked &
                      (st_ff.err_cnt != '1);
  assign bit_inc    = rx_bit_valid & ~chk_out.checker_unlocked &
                      (st_ff.bit_cnt != '1);
  assign upd_rise   = upd_req & ~st_ff.upd_req_prev;
  assign rd_latched = acc_rd & (idx == BSAC_IDX_LATCHED);

  // One cell per latched flag; a set in the clearing cycle wins, so no event is lost
  generate
    for (genvar g = 0; g < 4; g++)
    begin : g_flag
      assign nxt_latched[g] = flag_set[g] |
                              (st_ff.latched[g] & ~(rd_latched & st_ff.rdata[g]));
    end
  endgenerate

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    nxt_st = st_ff;

    nxt_st.upd_req_prev  = upd_req;
    nxt_st.upd_stat_prev = upd_status;
    nxt_st.nz_prev       = nonzero_status;
    nxt_st.unl_prev      = chk_out.checker_unlocked;
    nxt_st.resync_prev   = st_ff.upd_ctl[BSAC_UPD_MAN_RESYNC];

    if (err_inc)
      nxt_st.err_cnt = st_ff.err_cnt + ERR_W'(1);
    if (bit_inc)
      nxt_st.bit_cnt = st_ff.bit_cnt + BIT_W'(1);

    // Snapshot and restart; this cycle's increment carries into the new period
    if (upd_rise)
    begin
      nxt_st.err_snap = st_ff.err_cnt;
      nxt_st.bit_snap = st_ff.bit_cnt;
      nxt_st.err_cnt  = ERR_W'(err_inc);
      nxt_st.bit_cnt  = BIT_W'(bit_inc);
      nxt_st.upd_done = 1'b1;
    end
    else if (!upd_req)
      nxt_st.upd_done = 1'b0;

    // Clear only the bits the read returned
    nxt_st.latched = nxt_latched;

    if (acc_wr)
    begin
      case (idx)
        BSAC_IDX_INSERT_CTL:
          nxt_st.ins_ctl = pwdata[1:0];
        BSAC_IDX_IRQ_EN:
          nxt_st.irq_en = pwdata[3:0];
        BSAC_IDX_UPDATE_CTL:
          nxt_st.upd_ctl = pwdata[3:0];
        default:
          nxt_st.upd_ctl = st_ff.upd_ctl;
      endcase
    end

    // Read data is fetched in setup so the output comes straight from a flop
    nxt_st.slverr = 1'b0;
    if (setup_any)
    begin
      nxt_st.slverr = ~aligned | ~bsac_mapped(idx);
      nxt_st.rdata  = 32'h00000000;
    end
    if (setup_rd && aligned)
    begin
      case (idx)
        BSAC_IDX_INSERT_CTL: nxt_st.rdata = bsac_byte({6'h00, st_ff.ins_ctl});
        BSAC_IDX_STATUS:     nxt_st.rdata = bsac_byte({4'h0, status_bits});
        BSAC_IDX_LATCHED:    nxt_st.rdata = bsac_byte({4'h0, st_ff.latched});
        BSAC_IDX_IRQ_EN:     nxt_st.rdata = bsac_byte({4'h0, st_ff.irq_en});
        BSAC_IDX_UPDATE_CTL: nxt_st.rdata = bsac_byte({4'h0, st_ff.upd_ctl});
        BSAC_IDX_ERR_CNT0:   nxt_st.rdata = bsac_byte(st_ff.err_snap[7:0]);
        BSAC_IDX_ERR_CNT1:   nxt_st.rdata = bsac_byte(st_ff.err_snap[15:8]);
        BSAC_IDX_ERR_CNT2:   nxt_st.rdata = bsac_byte(st_ff.err_snap[23:16]);
        BSAC_IDX_BIT_CNT0:   nxt_st.rdata = bsac_byte(st_ff.bit_snap[7:0]);
        BSAC_IDX_BIT_CNT1:   nxt_st.rdata = bsac_byte(st_ff.bit_snap[15:8]);
        BSAC_IDX_BIT_CNT2:   nxt_st.rdata = bsac_byte(st_ff.bit_snap[23:16]);
        BSAC_IDX_BIT_CNT3:   nxt_st.rdata = bsac_byte(st_ff.bit_snap[31:24]);
        default:             nxt_st.rdata = 32'h00000000;
      endcase
    end

    nxt_st.irq = |(nxt_st.latched & nxt_st.irq_en);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_ff <= TOP_RST;
    else
      st_ff <= nxt_st;
  end

  assign prdata           = st_ff.rdata;
  assign pready           = 1'b1;
  assign pslverr          = st_ff.slverr & psel & penable;
  assign checker_unlocked = chk_out.checker_unlocked;
  assign irq              = st_ff.irq;

endmodule // bsac_top

// *** tb/bsac_props.sv ***
`timescale 1ns/100ps

// ****************************************************************
// Port-level checks of the tester status block
// ****************************************************************
module bsac_props
  import bsac_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              rx_bit_valid,
  input wire logic              rx_bit_mismatch,
  input wire logic              external_insert_input,
  input wire logic              external_update_request,
  input wire logic              insert_trigger,
  input wire logic              checker_unlocked,
  input wire logic              irq
);
  logic [7:0] idx;
  logic       acc;
  logic       hit;
  logic       req;
  logic [1:0] ins_ff;
  logic [3:0] en_ff;
  logic [1:0] upd_ff;

  assign idx = paddr[9:2];
  assign acc = psel && penable;
  assign hit = paddr[1:0] == 2'h0 && paddr[ADDR_W-1:10] == '0 &&
               idx inside {8'h08, 8'h0C, 8'h0E, 8'h10, 8'h12, 8'h14, 8'h15, 8'h16,
                           8'h18, 8'h19, 8'h1A, 8'h1B};
  assign req = upd_ff[1] ? external_update_request : upd_ff[0];

  // Shadows of the control registers, so the checks need no internal probes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ins_ff <= 2'h0;
      en_ff  <= 4'h0;
      upd_ff <= 2'h0;
    end
    else if (acc && pwrite && pready && hit)
    begin
      if (idx == BSAC_IDX_INSERT_CTL) ins_ff <= pwdata[1:0];
      if (idx == BSAC_IDX_IRQ_EN) en_ff <= pwdata[3:0];
      if (idx == BSAC_IDX_UPDATE_CTL) upd_ff <= pwdata[1:0];
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_ready_high: assert property (acc |-> pready)
    else $error("pready low in access phase");
  a_err_idle: assert property (!acc |-> !pslverr)
    else $error("pslverr outside access phase");
  a_err_decode: assert property (acc |-> pslverr == !hit)
    else $error("pslverr does not match address decode");
  a_read_upper: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_trig_mux: assert property (insert_trigger == (ins_ff[0] ? external_insert_input : ins_ff[1]))
    else $error("insert trigger from wrong source");
  a_irq_masked: assert property (en_ff == 4'h0 && $past(en_ff) == 4'h0 |-> !irq)
    else $error("irq high with all enables clear");
  a_irq_cause: assert property ($rose(irq) |-> en_ff != 4'h0)
    else $error("irq rose without an enable");
  a_upd_low: assert property (acc && !pwrite && idx == BSAC_IDX_STATUS && !$past(req)
                              |-> !prdata[3])
    else $error("update done read high while request low");

  c_lock: cover property ($fell(checker_unlocked));
  c_irq: cover property ($rose(irq));
  c_refuse: cover property (acc && pslverr);
endmodule // bsac_props

bind bsac_top bsac_props #(.ADDR_W(ADDR_W)) u_props
(
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .rx_bit_valid, .rx_bit_mismatch, .external_insert_input, .external_update_request,
  .insert_trigger, .checker_unlocked, .irq
);

// *** tb/tb_bsac_top.sv ***
`timescale 1ns/100ps

module tb_bsac_top
  import bsac_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic        pready, pslverr, rd_e, insert_trigger, checker_unlocked, irq;
  logic        rx_bit_valid = 1'b0, rx_bit_mismatch = 1'b0;
  logic        external_insert_input = 1'b0, external_update_request = 1'b0;
  int          err_count = 0;
  int          total_checks = 0;
  logic [7:0]  tab [10] = '{8'h08, 8'h10, 8'h12, 8'h14, 8'h15, 8'h16, 8'h18, 8'h19, 8'h1A, 8'h1B};

  always #12.5 pclk = ~pclk;

  // Short lock run keeps the hunting phase brief
  bsac_top #(.LOCK_RUN(4)) dut_u
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rx_bit_valid, .rx_bit_mismatch, .external_insert_input, .external_update_request,
    .insert_trigger, .checker_unlocked, .irq
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask

  task automatic chkb(input string nm, input logic exp, input logic got);
    chk(nm, {31'h0, exp}, {31'h0, got});
  endtask

  task automatic wrap_up;
    if (err_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // An idle edge after each transfer, so no signal is assigned twice in one step
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    logic rdy;
    n = 0;
    rdy = 1'b0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer copied in the half cycle before the access edge, where it is settled
    do
    begin
      @(negedge pclk);
      rdy = pready;
      rd_q = prdata;
      rd_e = pslverr;
      @(posedge pclk);
      n++;
    end
    while (rdy !== 1'b1 && n < 40);
    chkb("pready", 1'b1, rdy);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    xfer(1'b1, {2'h0, idx, 2'h0}, d);
  endtask

  task automatic rd(input string nm, input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, {2'h0, idx, 2'h0}, 32'h0);
    chk(nm, exp, rd_q);
  endtask

  task automatic send(input int n, input logic mis);
    repeat (n)
    begin
      rx_bit_valid <= 1'b1;
      rx_bit_mismatch <= mis;
      @(posedge pclk);
      rx_bit_valid <= 1'b0;
      @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    rd("latched", 8'h0E, 32'h0);
    rd("status", 8'h0C, 32'h1);
    foreach (tab[i])
      rd("reset value", tab[i], 32'h0);
    rd("latched cleared", 8'h0E, 32'h0);
    rd("unmapped data", 8'h20, 32'h0);
    chkb("unmapped err", 1'b1, rd_e);
    xfer(1'b0, 12'h031, 32'h0);
    chkb("misaligned err", 1'b1, rd_e);
  endtask

  task automatic t_insert;
    wr(8'h08, 32'h2);
    chkb("trigger", 1'b1, insert_trigger);
    wr(8'h08, 32'h0);
    chkb("trigger", 1'b0, insert_trigger);
    external_insert_input <= 1'b1;
    @(posedge pclk);
    chkb("trigger", 1'b0, insert_trigger);
    external_insert_input <= 1'b0;
    wr(8'h08, 32'h1);
    chkb("trigger", 1'b0, insert_trigger);
    external_insert_input <= 1'b1;
    @(posedge pclk);
    chkb("trigger", 1'b1, insert_trigger);
    external_insert_input <= 1'b0;
    @(posedge pclk);
    chkb("trigger", 1'b0, insert_trigger);
    wr(8'h08, 32'h0);
  endtask

  task automatic t_count;
    send(4, 1'b0);
    chkb("unlocked", 1'b0, checker_unlocked);
    rd("latched", 8'h0E, 32'h1);
    send(3, 1'b0);
    send(1, 1'b1);
    send(3, 1'b0);
    send(1, 1'b1);
    rd("status", 8'h0C, 32'h2);
    chkb("irq", 1'b0, irq);
    wr(8'h10, 32'h4);
    repeat (3) @(posedge pclk);
    chkb("irq", 1'b1, irq);
    rd("latched", 8'h0E, 32'h6);
    repeat (3) @(posedge pclk);
    chkb("irq", 1'b0, irq);
    wr(8'h12, 32'h1);
    repeat (4) @(posedge pclk);
    rd("status", 8'h0C, 32'h8);
    rd("latched", 8'h0E, 32'h8);
    rd("err0", 8'h14, 32'h2);
    rd("err1", 8'h15, 32'h0);
    rd("err2", 8'h16, 32'h0);
    rd("bit0", 8'h18, 32'h8);
    rd("bit1", 8'h19, 32'h0);
    rd("bit2", 8'h1A, 32'h0);
    rd("bit3", 8'h1B, 32'h0);
    wr(8'h12, 32'h0);
    rd("status", 8'h0C, 32'h0);
  endtask

  // Five dense mismatches at window offset 8 must not drop lock; seventeen must
  task automatic t_resync;
    send(128, 1'b0);
    send(5, 1'b1);
    chkb("unlocked", 1'b0, checker_unlocked);
    send(12, 1'b1);
    chkb("unlocked", 1'b1, checker_unlocked);
    wr(8'h12, 32'h2);
    external_update_request <= 1'b1;
    repeat (4) @(posedge pclk);
    rd("err0", 8'h14, 32'h5);
    rd("bit0", 8'h18, 32'h86);
    rd("bit1", 8'h19, 32'h0);
    external_update_request <= 1'b0;
    send(4, 1'b1);
    external_update_request <= 1'b1;
    repeat (4) @(posedge pclk);
    rd("status", 8'h0C, 32'h9);
    rd("err0", 8'h14, 32'h0);
    rd("bit0", 8'h18, 32'h0);
    external_update_request <= 1'b0;
    @(posedge pclk);
    rd("status", 8'h0C, 32'h1);
    send(4, 1'b0);
    wr(8'h12, 32'h4);
    send(8, 1'b1);
    chkb("unlocked", 1'b0, checker_unlocked);
    wr(8'h12, 32'hC);
    repeat (2) @(posedge pclk);
    chkb("unlocked", 1'b1, checker_unlocked);
    wr(8'h12, 32'h0);
  endtask

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_insert();
    t_count();
    t_resync();
    wrap_up();
  end

  initial
  begin
    #2000000;
    err_count++;
    wrap_up();
  end
endmodule // tb_bsac_top
